// ---- line_regs_consts.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef LINE_REGS_CONSTS_SVH
`define LINE_REGS_CONSTS_SVH
`define ADDR_STATUS_CTRL 6'h10
`define ADDR_LINE_MODE 6'h11
`define ADDR_EQ_GAIN 6'h12
`define ADDR_WAVE_PTR 6'h13
`define ADDR_PATTERN_CTRL 6'h14
`define ADDR_ERR_COUNT 6'h15
`define BIT_LOS 0
`define BIT_NETWORK_LOOPBACK_DETECTED 1
`define BIT_REMOTE_LOOPBACK 5
`define BIT_LOCAL_LOOPBACK 6
`define BIT_SEND_ALL_ONES 7
`define BIT_SH_SELECT 0
`define BIT_TX_ZERO_SUB_ENABLE 2
`define BIT_RX_ZERO_SUB_ENABLE 3
`define BIT_ACT_CODE 3
`define BIT_DEACT_CODE 4
`define BIT_PULSE_RAM 6
`define BIT_AIS 7
`define BIT_PRBS_GEN 1
`define BIT_PRBS_LOCK 2
`define BIT_PRBS_INJ 3
`define BIT_PRBS_DET 4
`define BIT_PRBS_CLR 5
`define BIT_LONG_HAUL_E1_SELECT 6
`define BIT_PRBS_ROUTE 7
`define REG_RESET 8'h00
`define COUNT_MAX 8'hFF
`define LOS_ZEROS 8'd175
`define AIS_ONES 8'd48
`define WAVE_LAST 8'h29
`define LOCK_RUN 5'd20
`define DEACT_PATTERN 6'b001001
`define ACT_PATTERN 10'b0000100001
`endif

// ---- line_regs_pkg.sv ----
// Types shared by the line interface register block
package line_regs_pkg;
  typedef enum logic [1:0] {
    ser_cmd,
    ser_ptr,
    ser_data,
    ser_done
  } ser_state_t;
endpackage

// ---- line_interface_host_registers.sv ----
// Host-mode register bank of the line interface with serial port and pattern test logic
// Operation
// R1: Alarm all-ones flag sets while receiver sees continuous ones.
// R2: Flag clears on first read after all-ones condition has gone.
// R3: All-ones alarm interrupts unless host wrote the flag bit as one.
// R4: Custom pulse enable selects waveform memory shapes over built-in ones.
// R5: Long haul deactivate bit repeats 001001 on transmit until cleared.
// R6: Long haul activate bit repeats 0000100001 on transmit until cleared.
// R7: Bit 0 of 0x11 picks short haul, selecting bit meanings there.
// R8: Long haul E1 bit selects HDB3 and 2^15-1; ignored in short haul.
// R9: Short haul, unipolar: receive coder bit enables zero substitution over pin.
// R10: Short haul, unipolar: transmit coder bit enables zero substitution over pin.
// R11: 0x12 reports five-bit equalizer gain step, upper bits don't care.
// R12: 0x13 is waveform memory pointer; host uses special sequence.
// R13: Generator emits pattern; route bit picks data outputs or line.
// R14: Error count clear bit zeroes counter, self-clears, reads zero.
// R15: Detector enable runs detector and counts errors at 0x15.
// R16: Inject written one then zero corrupts exactly one output bit.
// R17: Lock bit reads one while detector is synchronised; host writes zero.
// R18: Error counter saturates at 255 and holds until cleared.
// R19: Interrupt low on change of signal loss, all-ones or loopback.
// R20: Writing one clears, updates code bits and masks; zero unmasks; reads never clear.
// R21: Long haul 0x10 bits 7:5 give encoded status.
// R22: Short haul uses same encoding, codes 101 and 111 unused.
// R23: Memory access is command to 0x13, location byte, then one data byte.
// R24: Signal absent flag sets after 175 zeros, clears on valid signal.
// R25: Loopback flag sets when loopback code detected in receive signal.
// R26: Command byte: read/write bit, six address bits, one ignored bit.
// R27: While locked, each received bit disagreeing with reference adds one.
`timescale 1ns/1ps
`include "line_regs_consts.svh"
module line_interface_host_registers
  import line_regs_pkg::*;
#(
  parameter int WAVE_DEPTH = 42
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic line_clk,
  input wire logic ser_clk,
  input wire logic ser_cs_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe_n,
  input wire logic rx_data_pos,
  input wire logic rx_data_minus,
  input wire logic tx_data_pos,
  input wire logic tx_negative_rail_input,
  input wire logic [4:0] rx_eq_gain,
  input wire logic network_loopback_code,
  output logic line_tx_bit,
  output logic rx_pattern_out,
  output logic rx_zero_sub_active,
  output logic tx_zero_sub_active,
  output logic e1_coding,
  output logic custom_pulse_enable,
  output logic [6:0] wave_sample,
  output logic int_n
);
  // Serial port pins synchronised into core domain
  logic [2:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] din_s;
  logic [5:0] pin_a, pin_b;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclk_s <= 3'h0;
      cs_s <= 2'h3;
      din_s <= 2'h0;
      pin_a <= 6'h00;
      pin_b <= 6'h00;
    end else begin
      sclk_s <= {sclk_s[1:0], ser_clk};
      cs_s <= {cs_s[0], ser_cs_n};
      din_s <= {din_s[0], ser_din};
      pin_a <= {tx_negative_rail_input, rx_eq_gain};
      pin_b <= pin_a;
    end
  end
  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];

  // Line-side status synchronised from link domain
  logic [1:0] los_s, ais_s, lock_s, nl_s, err_t_s;
  logic [2:0] err_tog_d;
  logic los_line, ais_line, lock_line, err_tog;

  // Registers
  logic [7:0] ctrl1, ctrl2, ctrl3, wave_ptr, err_count;
  logic [6:0] wave_mem [0:WAVE_DEPTH-1];
  logic los_flag, network_loopback_detected_flag, ais_flag;
  logic los_mask, network_loopback_detected_mask, ais_mask;
  logic los_chg, network_loopback_detected_chg;
  logic inject_req;

  wire short_haul = ctrl2[`BIT_SH_SELECT]; // R7
  wire e1_mode = ~short_haul & ctrl3[`BIT_LONG_HAUL_E1_SELECT]; // R8

  // Serial framing
  ser_state_t st;
  logic [3:0] bitcnt;
  logic [7:0] shreg, tx_shift;
  logic is_read;
  logic [5:0] addr;

  function automatic logic [7:0] status_code(input logic [7:0] c1, input logic lchg,
                                             input logic nchg, input logic sh);
    logic [2:0] code;
    code = 3'h0;
    if (lchg && nchg && !sh) code = 3'h7; // R21
    else if (nchg && !sh) code = 3'h5; // R22
    else if (lchg) code = 3'h3;
    else if (c1[`BIT_SEND_ALL_ONES] && c1[`BIT_LOCAL_LOOPBACK]) code = 3'h6;
    else if (c1[`BIT_SEND_ALL_ONES]) code = 3'h4;
    else if (c1[`BIT_LOCAL_LOOPBACK]) code = 3'h2;
    else if (c1[`BIT_REMOTE_LOOPBACK]) code = 3'h1;
    status_code = {code, c1[4:2], sh ? 1'b0 : network_loopback_detected_flag, los_flag};
  endfunction

  function automatic logic [7:0] read_mux(input logic [5:0] a, input logic [7:0] ptr);
    case (a)
      `ADDR_STATUS_CTRL: read_mux = status_code(ctrl1, los_chg, network_loopback_detected_chg, short_haul);
      `ADDR_LINE_MODE: read_mux = {ais_flag, ctrl2[6:0]};
      `ADDR_EQ_GAIN: read_mux = {3'h0, pin_b[4:0]}; // R11
      `ADDR_WAVE_PTR: read_mux = (ptr <= `WAVE_LAST) ? {1'b0, wave_mem[ptr[5:0]]} : 8'h00;
      `ADDR_PATTERN_CTRL: read_mux = {ctrl3[7:6], 1'b0, ctrl3[4:3], lock_s[1], ctrl3[1:0]}; // R14 R17
      `ADDR_ERR_COUNT: read_mux = err_count;
      default: read_mux = 8'h00;
    endcase
  endfunction

  logic wr_pulse, rd_pulse;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= ser_cmd;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      addr <= 6'h00;
      wave_ptr <= `REG_RESET;
      tx_shift <= 8'h00;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      ser_dout <= 1'b0;
      ser_dout_oe_n <= 1'b1;
    end else begin
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (cs_s[1]) begin
        st <= ser_cmd;
        bitcnt <= 4'h0;
        ser_dout_oe_n <= 1'b1;
      end else if (sclk_rise) begin
        shreg <= {din_s[1], shreg[7:1]};
        bitcnt <= bitcnt + 4'h1;
        if (bitcnt == 4'h7) begin
          bitcnt <= 4'h0;
          case (st)
            ser_cmd: begin
              // First bit is read/write, next six the address, the last one ignored
              addr <= shreg[7:2]; // R26
              is_read <= shreg[1]; // R26
              st <= (shreg[7:2] == `ADDR_WAVE_PTR) ? ser_ptr : ser_data; // R23
              if (shreg[1] && shreg[7:2] != `ADDR_WAVE_PTR) begin
                tx_shift <= read_mux(shreg[7:2], wave_ptr);
                rd_pulse <= 1'b1;
                ser_dout_oe_n <= 1'b0;
              end
            end
            ser_ptr: begin
              wave_ptr <= {din_s[1], shreg[7:1]}; // R12
              st <= ser_data;
              if (is_read) begin
                tx_shift <= read_mux(addr, {din_s[1], shreg[7:1]});
                ser_dout_oe_n <= 1'b0;
              end
            end
            ser_data: begin
              st <= ser_done;
              wr_pulse <= ~is_read;
            end
            default: st <= ser_done;
          endcase
        end
      end else if (sclk_fall && !ser_dout_oe_n) begin
        ser_dout <= tx_shift[0];
        tx_shift <= {1'b0, tx_shift[7:1]};
        if (st == ser_done) ser_dout_oe_n <= 1'b1;
      end
    end
  end

  // Register writes
  wire wr_c1 = wr_pulse && addr == `ADDR_STATUS_CTRL;
  wire wr_c2 = wr_pulse && addr == `ADDR_LINE_MODE;
  wire wr_c3 = wr_pulse && addr == `ADDR_PATTERN_CTRL;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl1 <= `REG_RESET;
      ctrl2 <= `REG_RESET;
      ctrl3 <= `REG_RESET;
      los_mask <= 1'b0;
      network_loopback_detected_mask <= 1'b0;
      ais_mask <= 1'b0;
      inject_req <= 1'b0;
    end else begin
      inject_req <= 1'b0;
      if (wr_c1) begin
        ctrl1 <= shreg;
        los_mask <= shreg[`BIT_LOS]; // R20
        network_loopback_detected_mask <= shreg[`BIT_NETWORK_LOOPBACK_DETECTED]; // R20
      end
      if (wr_c2) begin
        ctrl2 <= {1'b0, shreg[6:0]};
        ais_mask <= shreg[`BIT_AIS]; // R3
      end
      if (wr_c3) begin
        ctrl3 <= {shreg[7:6], 1'b0, shreg[4:3], 1'b0, shreg[1:0]}; // R14 R17
        inject_req <= ctrl3[`BIT_PRBS_INJ] & ~shreg[`BIT_PRBS_INJ]; // R16
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_pulse && addr == `ADDR_WAVE_PTR && wave_ptr <= `WAVE_LAST)
      wave_mem[wave_ptr[5:0]] <= shreg[6:0];
  end

  // Status flags with change tracking; events win over clears
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      los_s <= 2'h0;
      ais_s <= 2'h0;
      lock_s <= 2'h0;
      nl_s <= 2'h0;
      los_flag <= 1'b0;
      network_loopback_detected_flag <= 1'b0;
      ais_flag <= 1'b0;
      los_chg <= 1'b0;
      network_loopback_detected_chg <= 1'b0;
    end else begin
      los_s <= {los_s[0], los_line};
      ais_s <= {ais_s[0], ais_line};
      lock_s <= {lock_s[0], lock_line};
      nl_s <= {nl_s[0], network_loopback_code};
      los_flag <= los_s[1]; // R24
      network_loopback_detected_flag <= nl_s[1]; // R25
      if (ais_s[1]) ais_flag <= 1'b1; // R1
      else if (rd_pulse && addr == `ADDR_LINE_MODE) ais_flag <= 1'b0; // R2
      if (los_flag != los_s[1] && !los_mask) los_chg <= 1'b1; // R19
      else if (wr_c1 && shreg[`BIT_LOS]) los_chg <= 1'b0; // R20
      if (network_loopback_detected_flag != nl_s[1] && !network_loopback_detected_mask) network_loopback_detected_chg <= 1'b1; // R19
      else if (wr_c1 && shreg[`BIT_NETWORK_LOOPBACK_DETECTED]) network_loopback_detected_chg <= 1'b0; // R20
    end
  end

  // Error counter fed by toggle from link domain
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      err_t_s <= 2'h0;
      err_tog_d <= 3'h0;
      err_count <= 8'h00;
    end else begin
      err_t_s <= {err_t_s[0], err_tog};
      err_tog_d <= {err_tog_d[1:0], err_t_s[1]};
      if (wr_c3 && shreg[`BIT_PRBS_CLR]) err_count <= 8'h00; // R14
      else if ((err_tog_d[0] != err_t_s[1]) && err_count != `COUNT_MAX) // R18
        err_count <= err_count + 8'h01; // R15
    end
  end

  // Outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_n <= 1'b1;
      rx_zero_sub_active <= 1'b0;
      tx_zero_sub_active <= 1'b0;
      e1_coding <= 1'b0;
      custom_pulse_enable <= 1'b0;
      wave_sample <= 7'h00;
    end else begin
      int_n <= ~(los_chg | network_loopback_detected_chg | (ais_flag & ~ais_mask)); // R19 R3
      rx_zero_sub_active <= short_haul ? (pin_b[5] & ctrl2[`BIT_RX_ZERO_SUB_ENABLE])
                                       : (pin_b[5] & ctrl1[2]); // R9
      tx_zero_sub_active <= short_haul ? (pin_b[5] & ctrl2[`BIT_TX_ZERO_SUB_ENABLE])
                                       : (pin_b[5] & ctrl1[2]); // R10
      e1_coding <= e1_mode; // R8
      custom_pulse_enable <= ctrl2[`BIT_PULSE_RAM]; // R4
      wave_sample <= wave_mem[0];
    end
  end

  // Link domain: control levels synchronised in
  logic [1:0] gen_l, det_l, route_l, e1_l, act_l, deact_l, lh_l, rst_l;
  logic inj_tog;
  always_ff @(posedge core_clk) begin
    if (sys_rst) inj_tog <= 1'b0;
    else if (inject_req) inj_tog <= ~inj_tog;
  end
  logic [2:0] inj_sync;
  logic [19:0] gen_lfsr, ref_lfsr;
  logic [9:0] code_sh;
  logic [7:0] zeros, ones;
  logic [4:0] run;
  always_ff @(posedge line_clk) begin
    gen_l <= {gen_l[0], ctrl3[`BIT_PRBS_GEN]};
    det_l <= {det_l[0], ctrl3[`BIT_PRBS_DET]};
    route_l <= {route_l[0], ctrl3[`BIT_PRBS_ROUTE]};
    e1_l <= {e1_l[0], e1_mode};
    act_l <= {act_l[0], ctrl2[`BIT_ACT_CODE]};
    deact_l <= {deact_l[0], ctrl2[`BIT_DEACT_CODE]};
    lh_l <= {lh_l[0], ~short_haul};
    inj_sync <= {inj_sync[1:0], inj_tog};
    rst_l <= {rst_l[0], sys_rst};
  end
  wire rx_bit = rx_data_pos | rx_data_minus;
  wire chk_bit = route_l[1] ? rx_bit : tx_data_pos; // R13
  function automatic logic fb(input logic [19:0] s, input logic e1);
    fb = e1 ? (s[14] ^ s[13]) : (s[19] ^ s[16]);
  endfunction
  always_ff @(posedge line_clk) begin
    if (rst_l[1]) begin
      ones <= 8'h00;
      gen_lfsr <= 20'h00001;
      ref_lfsr <= 20'h00001;
      code_sh <= 10'h000;
      zeros <= 8'h00;
      run <= 5'h00;
      los_line <= 1'b0;
      ais_line <= 1'b0;
      lock_line <= 1'b0;
      err_tog <= 1'b0;
      line_tx_bit <= 1'b0;
      rx_pattern_out <= 1'b0;
    end else begin
      gen_lfsr <= {gen_lfsr[18:0], fb(gen_lfsr, e1_l[1])};
      if (lh_l[1] && deact_l[1]) begin
        code_sh <= (code_sh[9:6] != 4'hF) ? {4'hF, `DEACT_PATTERN} : {4'hF, code_sh[4:0], code_sh[5]}; // R5
        line_tx_bit <= code_sh[5];
      end else if (lh_l[1] && act_l[1]) begin
        code_sh <= (code_sh == 10'h000 || code_sh[9:6] == 4'hF) ? `ACT_PATTERN : {code_sh[8:0], code_sh[9]}; // R6
        line_tx_bit <= code_sh[9];
      end else begin
        code_sh <= 10'h000;
        line_tx_bit <= gen_l[1] & route_l[1] & (gen_lfsr[0] ^ (inj_sync[2] != inj_sync[1])); // R13 R16
      end
      rx_pattern_out <= gen_l[1] & ~route_l[1] & (gen_lfsr[0] ^ (inj_sync[2] != inj_sync[1]));
      zeros <= rx_bit ? 8'h00 : (zeros == `LOS_ZEROS ? zeros : zeros + 8'h01);
      los_line <= (zeros >= `LOS_ZEROS - 8'd1) & ~rx_bit; // R24
      // Own run of marks so the alarm works with the pattern detector off
      ones <= ~rx_bit ? 8'h00 : (ones == `AIS_ONES ? ones : ones + 8'h01);
      ais_line <= (ones >= `AIS_ONES - 8'd1) & rx_bit; // R1
      ref_lfsr <= lock_line ? {ref_lfsr[18:0], fb(ref_lfsr, e1_l[1])} : {ref_lfsr[18:0], chk_bit};
      if (!det_l[1]) begin
        run <= 5'h00;
        lock_line <= 1'b0;
      end else if (!lock_line) begin
        run <= (chk_bit == fb(ref_lfsr, e1_l[1])) ? ((run == `LOCK_RUN) ? run : run + 5'h01) : 5'h00;
        lock_line <= run == `LOCK_RUN; // R17
      end else if (chk_bit != fb(ref_lfsr, e1_l[1])) begin
        err_tog <= ~err_tog; // R27
      end
    end
  end

  AST_CLR_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_c3 && shreg[`BIT_PRBS_CLR] |=> err_count == 8'h00) else $error("count not cleared"); // R14
  AST_SAT: assert property (@(posedge core_clk) disable iff (sys_rst)
    err_count == 8'hFF && !(wr_c3 && shreg[`BIT_PRBS_CLR]) |=> err_count == 8'hFF) else $error("count wrapped"); // R18
  AST_AIS_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    ais_s[1] |=> ais_flag) else $error("ais not set"); // R1
  AST_INT_AIS: assert property (@(posedge core_clk) disable iff (sys_rst)
    ais_flag && !ais_mask |=> !int_n) else $error("ais interrupt missing"); // R3
  AST_READ_KEEP: assert property (@(posedge core_clk) disable iff (sys_rst)
    los_chg && !wr_c1 |=> los_chg) else $error("change lost"); // R20
  AST_MODE: assert property (@(posedge core_clk) disable iff (sys_rst)
    short_haul |=> !e1_coding) else $error("e1 in short haul"); // R8
  AST_PULSE: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_c2 |-> ##2 custom_pulse_enable == $past(shreg[`BIT_PULSE_RAM], 2)) else $error("pulse enable"); // R4
  AST_INC: assert property (@(posedge core_clk) disable iff (sys_rst)
    err_count != 8'hFF && (err_tog_d[0] != err_t_s[1]) && !wr_c3 |=> err_count == $past(err_count) + 8'h01)
    else $error("count missed"); // R15
  COV_READ: cover property (@(posedge core_clk) rd_pulse);
  COV_WRITE: cover property (@(posedge core_clk) wr_c3);
  COV_SAT: cover property (@(posedge core_clk) err_count == 8'hFF);
endmodule

// ---- host_serial_model.sv ----
// Host microcontroller model for the clocked serial register port
`timescale 1ns/1ps
module host_serial_model (
  input wire logic core_clk,
  output logic ser_clk,
  output logic ser_cs_n,
  output logic ser_din,
  input wire logic ser_dout,
  input wire logic ser_dout_oe_n
);
  initial begin
    ser_clk = 1'b0;
    ser_cs_n = 1'b1;
    ser_din = 1'b0;
  end
  // Half serial period, slow enough for the two-stage input synchronisers
  task automatic half();
    repeat (6) @(negedge core_clk);
  endtask
  // One byte LSB first; input changes while the clock is low, read data taken at the rise
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      ser_din = tx[i];
      half();
      rx[i] = ser_dout_oe_n ? 1'bx : ser_dout;
      ser_clk = 1'b1;
      half();
      ser_clk = 1'b0;
    end
    // A released input line must not keep its last value
    ser_din = ~ser_din;
  endtask
  task automatic frame(input logic rd, input logic [5:0] addr, input logic use_loc, input logic [7:0] loc,
                       input logic [7:0] wd, output logic [7:0] rd_data);
    logic [7:0] unused;
    ser_cs_n = 1'b0;
    half();
    shift({1'b0, addr, rd}, unused);
    if (use_loc) shift(loc, unused);
    shift(wd, rd_data);
    repeat (4) @(negedge core_clk);
    ser_cs_n = 1'b1;
    half();
  endtask
endmodule

// ---- line_interface_host_registers_test.sv ----
// Self-checking bench for the line interface host register bank
`timescale 1ns/1ps
module line_interface_host_registers_test;
  logic core_clk, line_clk, sys_rst, ser_clk, ser_cs_n, ser_din, ser_dout, ser_dout_oe_n;
  logic rx_bit, tx_loop, tx_negative_rail_input, network_loopback_code, line_tx_bit, rx_pattern_out;
  logic rx_zero_sub_active, tx_zero_sub_active, e1_coding, custom_pulse_enable, int_n;
  logic [1:0] rx_mode;
  logic [4:0] rx_eq_gain;
  logic [6:0] wave_sample;
  logic [7:0] v, r;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // Receive source: 0 random, 1 marks on either rail, 2 silence, 3 looped from the line output
  wire rx_data_pos = rx_mode == 2'd3 ? line_tx_bit : rx_mode == 2'd2 ? 1'b0 : rx_bit;
  wire rx_data_minus = rx_mode == 2'd1 && !rx_bit;
  wire tx_data_pos = tx_loop ? rx_pattern_out : rx_bit;
  line_interface_host_registers dut_u (.core_clk, .sys_rst, .line_clk, .ser_clk, .ser_cs_n, .ser_din,
    .ser_dout, .ser_dout_oe_n, .rx_data_pos, .rx_data_minus, .tx_data_pos, .tx_negative_rail_input,
    .rx_eq_gain, .network_loopback_code, .line_tx_bit, .rx_pattern_out, .rx_zero_sub_active,
    .tx_zero_sub_active, .e1_coding, .custom_pulse_enable, .wave_sample, .int_n);
  host_serial_model host_u (.core_clk, .ser_clk, .ser_cs_n, .ser_din, .ser_dout, .ser_dout_oe_n);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    line_clk = 1'b0;
    #3.3;
    forever #7.5 line_clk = ~line_clk;
  end
  always @(negedge line_clk) rx_bit <= 1'($urandom);
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      $display("Error at %0t: run did not finish", $time);
      close_out();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    host_u.frame(1'b0, a, 1'b0, 8'h00, d, x);
    idle(3);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    host_u.frame(1'b1, a, 1'b0, 8'h00, 8'h00, r);
    chk(r & m, e);
  endtask
  function automatic int exp_ones(input logic [9:0] pat, input int len);
    return 30 / len * $countones(pat);
  endfunction
  // Transmitted loop code: period and density of ones over 30 line bits
  task automatic code_chk(input logic [9:0] pat, input int len);
    logic [29:0] b;
    logic hit, m;
    repeat (10) @(posedge line_clk);
    for (int i = 0; i < 30; i++) begin
      @(posedge line_clk);
      #1 b[i] = line_tx_bit;
    end
    chk(8'($countones(b)), 8'(exp_ones(pat, len)));
    chk({7'h00, (b >> len) === (b & ((30'h1 << (30 - len)) - 30'h1))}, 8'h01);
    // The bits must be some rotation of the pattern, sent first bit leftmost
    hit = 1'b0;
    for (int s = 0; s < len; s++) begin
      m = 1'b1;
      for (int i = 0; i < 30; i++) if (b[i] !== pat[len - 1 - (i + s) % len]) m = 1'b0;
      hit |= m;
    end
    chk({7'h00, hit}, 8'h01);
  endtask
  initial begin
    sys_rst = 1'b1;
    rx_mode = 2'd0;
    rx_bit = 1'b0;
    tx_loop = 1'b0;
    tx_negative_rail_input = 1'b1;
    network_loopback_code = 1'b0;
    rx_eq_gain = 5'h00;
    void'($urandom(91890));
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) sys_rst = 1'b0;
    idle(4);
    chk({6'h00, int_n, ser_dout_oe_n}, 8'h03);
    for (int a = 'h14; a <= 'h16; a++) rchk(6'(a), 8'hFF, 8'h00);
    wr(6'h16, 8'h5A);
    rchk(6'h16, 8'hFF, 8'h00);
    rx_eq_gain = 5'($urandom_range(1, 20));
    rchk(6'h12, 8'h1F, {3'b000, rx_eq_gain});
    v = {1'b0, 7'($urandom)};
    host_u.frame(1'b0, 6'h13, 1'b1, 8'h00, v, r);
    idle(3);
    chk({1'b0, wave_sample}, v);
    host_u.frame(1'b0, 6'h13, 1'b1, 8'h2A, ~v, r);
    idle(3);
    chk({1'b0, wave_sample}, v);
    host_u.frame(1'b1, 6'h13, 1'b1, 8'h00, 8'h00, r);
    chk(r & 8'h7F, v);
    for (int i = 1; i <= 4; i++) begin
      v = i == 4 ? 8'hC0 : 8'(8'h10 << i);
      wr(6'h10, v);
      rchk(6'h10, 8'hE0, v);
    end
    wr(6'h10, 8'h00);
    repeat (6) begin
      v = 8'($urandom) & 8'h4D;
      tx_negative_rail_input = 1'($urandom);
      wr(6'h11, v);
      chk({7'h00, custom_pulse_enable}, {7'h00, v[6]});
      if (v[0] && tx_negative_rail_input) begin
        chk({7'h00, tx_zero_sub_active}, {7'h00, v[2]});
        chk({7'h00, rx_zero_sub_active}, {7'h00, v[3]});
      end
    end
    tx_negative_rail_input = 1'b1;
    for (int e = 0; e < 2; e++) begin
      wr(6'h11, 8'h00);
      wr(6'h14, 8'(e << 6));
      chk({7'h00, e1_coding}, 8'(e));
    end
    wr(6'h14, 8'h00);
    wr(6'h11, 8'h10);
    code_chk(10'b0000001001, 6);
    wr(6'h11, 8'h08);
    code_chk(10'b0000100001, 10);
    wr(6'h11, 8'h00);
    // Route 0: T1 pattern over the data pins; route 1: E1 pattern over the line
    for (int rt = 0; rt < 2; rt++) begin
      wr(6'h14, 8'h00);
      v = {rt[0], rt[0], 6'h12};
      wr(6'h14, v | 8'h20);
      rx_mode = rt == 1 ? 2'd3 : 2'd0;
      tx_loop = rt == 0;
      idle(400);
      rchk(6'h14, 8'h24, 8'h04);
      rchk(6'h15, 8'hFF, 8'h00);
      wr(6'h14, v | 8'h08);
      wr(6'h14, v);
      idle(200);
      rchk(6'h15, 8'hFF, 8'h01);
      wr(6'h14, v | 8'h20);
      rchk(6'h15, 8'hFF, 8'h00);
    end
    wr(6'h14, 8'h00);
    rx_mode = 2'd0;
    tx_loop = 1'b0;
    rx_mode = 2'd1;
    idle(100);
    rchk(6'h11, 8'h80, 8'h80);
    chk({7'h00, int_n}, 8'h00);
    rx_mode = 2'd0;
    idle(50);
    rchk(6'h11, 8'h00, 8'h00);
    rchk(6'h11, 8'h80, 8'h00);
    wr(6'h11, 8'h80);
    chk({7'h00, int_n}, 8'h01);
    network_loopback_code = 1'b1;
    idle(100);
    rchk(6'h10, 8'hE2, 8'hA2);
    chk({7'h00, int_n}, 8'h00);
    wr(6'h11, 8'h81);
    host_u.frame(1'b1, 6'h10, 1'b0, 8'h00, 8'h00, r);
    chk({7'h00, (r & 8'hE0) !== 8'hA0}, 8'h01);
    chk({7'h00, int_n}, 8'h00);
    wr(6'h11, 8'h80);
    network_loopback_code = 1'b0;
    idle(100);
    wr(6'h10, 8'h02);
    chk({7'h00, int_n}, 8'h01);
    rchk(6'h10, 8'hE0, 8'h00);
    rx_mode = 2'd2;
    idle(400);
    rchk(6'h10, 8'hE1, 8'h61);
    chk({7'h00, int_n}, 8'h00);
    rx_mode = 2'd0;
    idle(50);
    wr(6'h10, 8'h03);
    chk({7'h00, int_n}, 8'h01);
    rchk(6'h10, 8'h01, 8'h00);
    close_out();
  end
endmodule
